// ### tci_host_model.sv
/*
  host master model: start, stop and byte transfers on an open-drain wire.
  assumes the bench resolves the wire with a pull-up (sda_q high = release).
*/
`timescale 1ns/1ps
module tci_host_model (
  // clock
  input wire logic sys_clk,
  // serial wire
  input wire logic sda_w,
  output logic scl_q,
  output logic sda_q
);
  // bit rate at or under the top
  // one bit is three half levels (scl high one, low two), so a third of the
  // shortest bit count keeps high 0.84 us, low 1.68 us
  localparam int half_cyc = (tci_pkg::TCI_SCL_MIN_CYC + 2) / 3;
  // bus idles released
  initial begin
    scl_q = 1'b1;
    sda_q = 1'b1;
  end
  // data set while scl low, sampled high
  task automatic clk_bit(input logic b, output logic s);
    sda_q <= b;
    repeat (half_cyc) @(posedge sys_clk);
    scl_q <= 1'b1;
    repeat (half_cyc) @(posedge sys_clk);
    s = sda_w;
    scl_q <= 1'b0;
    repeat (half_cyc) @(posedge sys_clk);
  endtask
  task automatic start();
    sda_q <= 1'b1;
    repeat (half_cyc) @(posedge sys_clk);
    scl_q <= 1'b1;
    repeat (half_cyc) @(posedge sys_clk);
    sda_q <= 1'b0;
    repeat (half_cyc) @(posedge sys_clk);
    scl_q <= 1'b0;
    // hold sda after the fall so the first data bit never races scl
    repeat (half_cyc) @(posedge sys_clk);
  endtask
  task automatic stop();
    sda_q <= 1'b0;
    repeat (half_cyc) @(posedge sys_clk);
    scl_q <= 1'b1;
    repeat (half_cyc) @(posedge sys_clk);
    sda_q <= 1'b1;
    repeat (half_cyc) @(posedge sys_clk);
  endtask
  // eight bits, then the target's acknowledge level
  task automatic wbyte(input logic [7:0] d, output logic ack);
    for (int i = 7; i >= 0; i--) clk_bit(d[i], ack);
    clk_bit(1'b1, ack);
  endtask
  // host acknowledges, or refuses the last byte
  task automatic rbyte(input logic nak, output logic [7:0] d);
    logic s;
    for (int i = 7; i >= 0; i--) clk_bit(1'b1, d[i]);
    clk_bit(nak, s);
  endtask
endmodule // tci_host_model

// ### tci_pkg.sv
/*
  package for the touch controller serial target port: bus target address
  pairs, byte framing constants, protocol states and the write-request
  carrier.
  assumes a 100 MHz system clock and a host that keeps SCL at or below the
  recommended bit rate.
*/
package tci_pkg;

  // system clock and recommended serial bit rate
  localparam int TCI_SYS_CLK_HZ = 100_000_000;
  localparam int TCI_SCL_MAX_HZ = 400_000;
  // fewest system clocks in one serial bit at the top rate
  localparam int TCI_SCL_MIN_CYC = TCI_SYS_CLK_HZ / TCI_SCL_MAX_HZ;

  // register pointer and data widths
  localparam int TCI_PTR_W = 16;
  localparam int TCI_DATA_W = 8;

  // target address pairs: even byte writes, odd byte reads
  localparam logic [7:0] TCI_ADDR_PRI_WR = 8'hba;
  localparam logic [7:0] TCI_ADDR_ALT_WR = 8'h28;

  // bits in one byte before the acknowledge clock
  localparam logic [3:0] TCI_BYTE_BITS = 4'h8;
  // pointer step after each byte moved
  localparam logic [TCI_PTR_W-1:0] TCI_PTR_STEP = 16'h0001;
  localparam logic [TCI_PTR_W-1:0] TCI_PTR_RST = 16'h0000;

  // pin input index into the synchroniser bank
  localparam int TCI_PIN_SCL = 0;
  localparam int TCI_PIN_SDA = 1;
  localparam int TCI_PIN_STRAP = 2;
  localparam int TCI_PIN_N = 3;

  // link states
  typedef enum logic [2:0] {
    TCI_ST_IDLE,
    TCI_ST_RX,
    TCI_ST_RX_ACK,
    TCI_ST_TX,
    TCI_ST_TX_ACK
  } tci_state_e;

  // which byte of a write transaction is arriving
  typedef enum logic [1:0] {
    TCI_PH_ADDR,
    TCI_PH_PTR_H,
    TCI_PH_PTR_L,
    TCI_PH_DATA
  } tci_phase_e;

  // one register write towards the controller core
  typedef struct packed {
    logic [TCI_PTR_W-1:0] addr;
    logic [TCI_DATA_W-1:0] data;
  } tci_wr_s;

endpackage

// ### tci_slave_port.sv
/*
  two-wire serial target port of the touch controller: start/stop detection,
  address match on one of two strapped pairs, 16-bit register pointer with
  auto increment, burst writes and continuous reads.
  assumes open-drain pins resolved outside (sda_oe_n low pulls the wire to
  sda_o), the register core answering a read strobe with rd_data on the
  next clock, and SCL far slower than sys_clk.
*/
`timescale 1ns/1ps

module tci_slave_port (
  // clock and reset
  input wire logic sys_clk,
  input wire logic rst_n,
  // serial pins
  input wire logic scl_i,
  input wire logic sda_i,
  output logic sda_o,
  output logic sda_oe_n,
  // address strap level, sampled once after reset release
  input wire logic addr_strap_i,
  // register core side
  output tci_pkg::tci_wr_s wr_req,
  output logic wr_stb,
  output logic rd_stb,
  output logic [tci_pkg::TCI_PTR_W-1:0] rd_addr,
  input wire logic [tci_pkg::TCI_DATA_W-1:0] rd_data,
  // status
  output logic busy,
  output logic alt_addr
);
  import tci_pkg::*;

  logic [1:0] rst_sync_r;
  logic rst_n_i;
  logic [TCI_PIN_N-1:0] pin_in;
  logic [TCI_PIN_N-1:0] meta_r;
  logic [TCI_PIN_N-1:0] sync_r;
  logic scl_d_r;
  logic sda_d_r;
  logic scl_s;
  logic sda_s;
  logic scl_rise;
  logic scl_fall;
  logic start_det;
  logic stop_det;
  logic [1:0] strap_wait_r;
  logic strap_done_r;
  logic alt_addr_r;
  tci_state_e state_r;
  tci_phase_e phase_r;
  logic [3:0] bit_cnt_r;
  logic [7:0] shift_r;
  logic rd_mode_r;
  logic [TCI_PTR_W-1:0] ptr_r;
  logic [7:0] tx_buf_r;
  logic rd_pend_r;
  logic sda_oe_n_r;
  logic sda_o_r;
  tci_wr_s wr_req_r;
  logic wr_stb_r;
  logic rd_stb_r;
  logic [TCI_PTR_W-1:0] rd_addr_r;
  logic busy_r;

  // true when the upper seven bits name the strapped target
  // strapped pair match
  function automatic logic addr_hit(input logic [7:0] b, input logic alt);
    logic [7:0] want;
    want = alt ? TCI_ADDR_ALT_WR : TCI_ADDR_PRI_WR;
    addr_hit = (b[7:1] == want[7:1]);
  endfunction

  // reset release through two flops; assertion stays asynchronous
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      rst_sync_r <= 2'h0;
    end else begin
      rst_sync_r <= {rst_sync_r[0], 1'b1};
    end
  end
  assign rst_n_i = rst_sync_r[1];

  // pins arrive from the host's clock world, so each takes two flops
  assign pin_in[TCI_PIN_SCL] = scl_i;
  assign pin_in[TCI_PIN_SDA] = sda_i;
  assign pin_in[TCI_PIN_STRAP] = addr_strap_i;
  generate
    for (genvar i = 0; i < TCI_PIN_N; i++) begin : g_sync
      always_ff @(posedge sys_clk or negedge rst_n_i) begin
        if (!rst_n_i) begin
          meta_r[i] <= 1'b1;
          sync_r[i] <= 1'b1;
        end else begin
          meta_r[i] <= pin_in[i];
          sync_r[i] <= meta_r[i];
        end
      end
    end
  endgenerate

  // previous synced levels for edge and condition detection
  always_ff @(posedge sys_clk or negedge rst_n_i) begin
    if (!rst_n_i) begin
      scl_d_r <= 1'b1;
      sda_d_r <= 1'b1;
    end else begin
      scl_d_r <= scl_s;
      sda_d_r <= sda_s;
    end
  end

  assign scl_s = sync_r[TCI_PIN_SCL];
  assign sda_s = sync_r[TCI_PIN_SDA];
  assign scl_rise = scl_s & ~scl_d_r;
  assign scl_fall = ~scl_s & scl_d_r;
  assign start_det = scl_s & scl_d_r & sda_d_r & ~sda_s;
  assign stop_det = scl_s & scl_d_r & ~sda_d_r & sda_s;

  // strap capture once
  // the synchroniser shows its reset value for two clocks after release, so
  // the capture waits for two fill clocks before it trusts the strap level
  always_ff @(posedge sys_clk or negedge rst_n_i) begin
    if (!rst_n_i) begin
      strap_wait_r <= 2'h0;
      strap_done_r <= 1'b0;
      alt_addr_r <= 1'b0;
    end else begin
      strap_wait_r <= {strap_wait_r[0], 1'b1};
      if (strap_wait_r[1] && !strap_done_r) begin
        strap_done_r <= 1'b1;
        alt_addr_r <= sync_r[TCI_PIN_STRAP];
      end
    end
  end

  // read data arrives one clock after the strobe; scl is far slower, so the
  // buffer is full long before the next falling edge needs it
  always_ff @(posedge sys_clk or negedge rst_n_i) begin
    if (!rst_n_i) begin
      rd_pend_r <= 1'b0;
      tx_buf_r <= 8'h00;
    end else begin
      rd_pend_r <= rd_stb_r;
      if (rd_pend_r) begin
        tx_buf_r <= rd_data;
      end
    end
  end

  // protocol engine: state, bit count, shifter, pointer and pin drive
  // reacts to host conditions first, then to scl edges
  always_ff @(posedge sys_clk or negedge rst_n_i) begin
    if (!rst_n_i) begin
      state_r <= TCI_ST_IDLE;
      phase_r <= TCI_PH_ADDR;
      bit_cnt_r <= 4'h0;
      shift_r <= 8'h00;
      rd_mode_r <= 1'b0;
      ptr_r <= TCI_PTR_RST;
      sda_oe_n_r <= 1'b1;
      wr_req_r <= '0;
      wr_stb_r <= 1'b0;
      rd_stb_r <= 1'b0;
      rd_addr_r <= TCI_PTR_RST;
    end else begin
      wr_stb_r <= 1'b0;
      rd_stb_r <= 1'b0;
      if (start_det) begin
        state_r <= TCI_ST_RX;
        phase_r <= TCI_PH_ADDR;
        bit_cnt_r <= 4'h0;
        sda_oe_n_r <= 1'b1;
      end else if (stop_det) begin
        state_r <= TCI_ST_IDLE;
        sda_oe_n_r <= 1'b1;
      end else begin
        case (state_r)
          TCI_ST_IDLE: begin
            sda_oe_n_r <= 1'b1;
          end
          TCI_ST_RX: begin
            if (scl_rise) begin
              shift_r <= {shift_r[6:0], sda_s};
              bit_cnt_r <= bit_cnt_r + 4'h1;
            end else if (scl_fall && bit_cnt_r == TCI_BYTE_BITS) begin
              bit_cnt_r <= 4'h0;
              state_r <= TCI_ST_RX_ACK;
              sda_oe_n_r <= 1'b0;
              case (phase_r)
                TCI_PH_ADDR: begin
                  if (addr_hit(shift_r, alt_addr_r)) begin
                    rd_mode_r <= shift_r[0];
                    phase_r <= TCI_PH_PTR_H;
                    if (shift_r[0]) begin
                      rd_stb_r <= 1'b1;
                      rd_addr_r <= ptr_r;
                      ptr_r <= ptr_r + TCI_PTR_STEP;
                    end
                  end else begin
                    state_r <= TCI_ST_IDLE;
                    sda_oe_n_r <= 1'b1;
                  end
                end
                TCI_PH_PTR_H: begin
                  ptr_r[TCI_PTR_W-1:8] <= shift_r;
                  phase_r <= TCI_PH_PTR_L;
                end
                TCI_PH_PTR_L: begin
                  ptr_r[7:0] <= shift_r;
                  phase_r <= TCI_PH_DATA;
                end
                TCI_PH_DATA: begin
                  wr_stb_r <= 1'b1;
                  wr_req_r <= '{addr: ptr_r, data: shift_r};
                  ptr_r <= ptr_r + TCI_PTR_STEP;
                end
                default: begin
                  state_r <= TCI_ST_IDLE;
                  sda_oe_n_r <= 1'b1;
                end
              endcase
            end
          end
          TCI_ST_RX_ACK: begin
            // ack clock ends on its falling edge; read goes on to data
            if (scl_fall) begin
              if (rd_mode_r) begin
                sda_oe_n_r <= tx_buf_r[7];
                shift_r <= {tx_buf_r[6:0], 1'b0};
                bit_cnt_r <= 4'h1;
                state_r <= TCI_ST_TX;
              end else begin
                sda_oe_n_r <= 1'b1;
                state_r <= TCI_ST_RX;
              end
            end
          end
          TCI_ST_TX: begin
            if (scl_fall) begin
              if (bit_cnt_r == TCI_BYTE_BITS) begin
                sda_oe_n_r <= 1'b1;
                bit_cnt_r <= 4'h0;
                state_r <= TCI_ST_TX_ACK;
              end else begin
                sda_oe_n_r <= shift_r[7];
                shift_r <= {shift_r[6:0], 1'b0};
                bit_cnt_r <= bit_cnt_r + 4'h1;
              end
            end
          end
          TCI_ST_TX_ACK: begin
            if (scl_rise) begin
              if (!sda_s) begin
                rd_stb_r <= 1'b1;
                rd_addr_r <= ptr_r;
                ptr_r <= ptr_r + TCI_PTR_STEP;
                state_r <= TCI_ST_RX_ACK;
              end else begin
                sda_oe_n_r <= 1'b1;
                state_r <= TCI_ST_IDLE;
              end
            end
          end
          default: begin
            state_r <= TCI_ST_IDLE;
            sda_oe_n_r <= 1'b1;
          end
        endcase
      end
    end
  end

  // open drain: the driven level is always low, only the enable moves
  always_ff @(posedge sys_clk or negedge rst_n_i) begin
    if (!rst_n_i) begin
      sda_o_r <= 1'b0;
      busy_r <= 1'b0;
    end else begin
      sda_o_r <= 1'b0;
      busy_r <= (state_r != TCI_ST_IDLE);
    end
  end

  // outputs straight from flops
  assign sda_o = sda_o_r;
  assign sda_oe_n = sda_oe_n_r;
  assign wr_req = wr_req_r;
  assign wr_stb = wr_stb_r;
  assign rd_stb = rd_stb_r;
  assign rd_addr = rd_addr_r;
  assign busy = busy_r;
  assign alt_addr = alt_addr_r;

endmodule // tci_slave_port

// ### tci_slave_port_chk.sv
/*
  checker for the serial target port: pin drive and register strobes.
  assumes binding to tci_slave_port and scl levels of many system clocks.
*/
`timescale 1ns/1ps
module tci_slave_port_chk (
  // clock and reset
  input wire logic sys_clk,
  input wire logic rst_n,
  // serial pins
  input wire logic scl_i,
  input wire logic sda_o,
  input wire logic sda_oe_n,
  // register side and status
  input wire tci_pkg::tci_wr_s wr_req,
  input wire logic wr_stb,
  input wire logic rd_stb,
  input wire logic [tci_pkg::TCI_PTR_W-1:0] rd_addr,
  input wire logic busy,
  input wire logic alt_addr
);
  import tci_pkg::*;
  default clocking @(posedge sys_clk); endclocking
  default disable iff (!rst_n);
  // acknowledge pulls low at the strobe and stands well into the bit
  sequence s_ack_hold;
    $fell(sda_oe_n) ##1 !sda_oe_n [*4];
  endsequence
  // a read fetch cannot repeat within eight system clocks
  sequence s_rd_quiet;
    !rd_stb [*8];
  endsequence
  property p_target; !sda_oe_n |-> busy && !sda_o; endproperty
  a_target: assert property (p_target) else $error("sda pulled outside a transfer");
  property p_scl_low; $changed(sda_oe_n) |-> !scl_i; endproperty
  a_scl_low: assert property (p_scl_low) else $error("sda drive moved while scl high");
  property p_wr_ack; wr_stb |-> s_ack_hold; endproperty
  a_wr_ack: assert property (p_wr_ack) else $error("written byte not acknowledged");
  property p_wr_pulse; wr_stb |=> !wr_stb; endproperty
  a_wr_pulse: assert property (p_wr_pulse) else $error("write strobe too long");
  property p_rd_space; rd_stb |=> s_rd_quiet; endproperty
  a_rd_space: assert property (p_rd_space) else $error("read fetches too close");
  property p_rd_addr; $changed(rd_addr) |-> rd_stb; endproperty
  a_rd_addr: assert property (p_rd_addr) else $error("read address moved alone");
  property p_wr_req; $changed(wr_req) |-> wr_stb; endproperty
  a_wr_req: assert property (p_wr_req) else $error("write request moved alone");
  property p_alt; busy |-> $stable(alt_addr); endproperty
  a_alt: assert property (p_alt) else $error("address pair moved in a transfer");
endmodule // tci_slave_port_chk

bind tci_slave_port tci_slave_port_chk u_chk (.sys_clk, .rst_n, .scl_i, .sda_o, .sda_oe_n,
  .wr_req, .wr_stb, .rd_stb, .rd_addr, .busy, .alt_addr);

// ### testbench.sv
/*
  bench for the serial target port: address table under both straps, burst
  write, repeated-start read and a refused address.
  assumes the host model as master and a core that reads back addr + 0x5a.
*/
`timescale 1ns/1ps
module testbench;
  import tci_pkg::*;
  typedef struct packed {
    logic [7:0] addr;
    logic nak_pri;
    logic nak_alt;
  } tci_row_s;
  logic sys_clk = 1'b0;
  logic rst_n = 1'b0;
  logic strap = 1'b0;
  logic scl_q, sda_q, sda_o, sda_oe_n, wr_stb, rd_stb, busy, alt_addr;
  logic [TCI_PTR_W-1:0] rd_addr;
  tci_wr_s wr_req;
  tci_wr_s wr_log[$];
  int failures = 0;
  int compares = 0;
  tci_row_s rows[6] = '{'{8'hba, 1'b0, 1'b1}, '{8'hbb, 1'b0, 1'b1}, '{8'h28, 1'b1, 1'b0},
    '{8'h29, 1'b1, 1'b0}, '{8'h00, 1'b1, 1'b1}, '{8'hbc, 1'b1, 1'b1}};
  // open-drain wire with pull-up; core answers from the read address
  wire sda_w = sda_q & (sda_oe_n | sda_o);
  wire [TCI_DATA_W-1:0] rd_data = rd_addr[7:0] + 8'h5a;
  always #5 sys_clk = ~sys_clk;
  tci_slave_port dut (.sys_clk, .rst_n, .scl_i(scl_q), .sda_i(sda_w), .sda_o, .sda_oe_n,
    .addr_strap_i(strap), .wr_req, .wr_stb, .rd_stb, .rd_addr, .rd_data, .busy, .alt_addr);
  tci_host_model host (.sys_clk, .sda_w, .scl_q, .sda_q);
  // log every register write
  always @(posedge sys_clk) if (wr_stb === 1'b1) wr_log.push_back(wr_req);
  task automatic check(input string name, input logic [23:0] seen, input logic [23:0] exp);
    compares++;
    if (seen !== exp) begin
      failures++;
      $display("unexpected %s: expected %h seen %h", name, exp, seen);
    end
  endtask
  task automatic results();
    $display("compares %0d failures %0d", compares, failures);
    if (failures == 0 && compares > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask
  // strap held across release so the pair is caught cleanly
  task automatic do_reset(input logic s);
    rst_n <= 1'b0;
    strap <= s;
    repeat (16) @(posedge sys_clk);
    rst_n <= 1'b1;
    repeat (12) @(posedge sys_clk);
  endtask
  // main sequence
  initial begin
    logic a;
    logic [7:0] d;
    for (int s = 0; s < 2; s++) begin
      do_reset(s[0]);
      check("alt_addr", alt_addr, s[0]);
      foreach (rows[i]) begin
        host.start();
        host.wbyte(rows[i].addr, a);
        check("address ack", a, s[0] ? rows[i].nak_alt : rows[i].nak_pri);
        if (a === 1'b0 && rows[i].addr[0]) host.rbyte(1'b1, d);
        host.stop();
      end
    end
    // burst write whose pointer carries out of the low byte
    wr_log.delete();
    host.start();
    host.wbyte(TCI_ADDR_ALT_WR, a);
    host.wbyte(8'h12, a);
    host.wbyte(8'hff, a);
    for (int i = 0; i < 3; i++) begin
      host.wbyte(8'(8'hc0 + i), a);
      check("data ack", a, 1'b0);
    end
    host.stop();
    check("busy after stop", busy, 1'b0);
    check("write count", 24'(wr_log.size()), 24'h3);
    foreach (wr_log[i]) check("write", wr_log[i], {16'h12ff + 16'(i), 8'(8'hc0 + i)});
    // pointer set, repeated start, three reads ending in refusal
    host.start();
    host.wbyte(TCI_ADDR_ALT_WR, a);
    host.wbyte(8'h40, a);
    host.wbyte(8'h00, a);
    host.start();
    host.wbyte(TCI_ADDR_ALT_WR | 8'h01, a);
    check("read address ack", a, 1'b0);
    check("busy in read", busy, 1'b1);
    for (int i = 0; i < 3; i++) begin
      host.rbyte(i == 2, d);
      check("read data", d, 8'(8'h5a + i));
    end
    check("sda released", sda_oe_n, 1'b1);
    check("read address", rd_addr, 24'h004002);
    host.stop();
    // foreign address, then a byte that must be ignored
    wr_log.delete();
    host.start();
    host.wbyte(8'h30, a);
    check("foreign ack", a, 1'b1);
    host.wbyte(8'h55, a);
    check("idle ack", a, 1'b1);
    host.stop();
    check("foreign writes", 24'(wr_log.size()), 24'h0);
    results();
  end
  // a hung run counts as a mismatch
  initial begin
    repeat (100000) @(posedge sys_clk);
    failures++;
    results();
  end
endmodule // testbench
